//--- ebi_decode.sv
// address decoder that picks the target region and handles boot remap
module ebi_decode
	import ebi_pkg::*;
(
	// request address and strap
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              boot_internal_in,
	// decoded target
	output target_e                target_out
);
	// the boot window goes to internal rom only when booting internally
	always_comb begin
		if (addr_in[SDRAM_BIT]) begin
			target_out = TGT_SDRAM;
		end else if (addr_in[RGN_LSB+3:RGN_LSB] == RGN_BOOT) begin
			target_out = boot_internal_in ? TGT_IROM : TGT_BOOT;
		end else if (addr_in[RGN_LSB+3:RGN_LSB] == RGN_CS1) begin
			target_out = TGT_CS1;
		end else if (addr_in[RGN_LSB+3:RGN_LSB] == RGN_CS2) begin
			target_out = TGT_CS2;
		end else if (addr_in[RGN_LSB+3:RGN_LSB] == RGN_CS4 && boot_internal_in) begin
			target_out = TGT_CS4;
		end else begin
			target_out = TGT_DEFAULT;
		end
	end
endmodule // ebi_decode

//--- ebi_mem_model.sv
// far-side model: async memory on the selects, isa peripheral and a 16-bit sdram
module ebi_mem_model
	import ebi_pkg::*;
#(
	parameter logic [15:0] SD_WORD = 16'hc3a5
) (
	// clock and bench knob for prompt or slow answers
	input  wire logic              clk_in,
	input  wire logic [3:0]        delay_in,
	// pins from the device
	input  wire logic [ADDR_W-1:1] addr_in,
	input  wire logic              rd_n_in,
	input  wire logic              cs_n_in,
	input  wire logic              prd_n_in,
	input  wire logic              pwr_n_in,
	input  wire logic              cas_n_in,
	input  wire logic              we_n_in,
	// pins toward the device
	output logic      [DATA_W-1:0] data_out,
	output logic                   ack_n_out,
	output logic                   ready_out
);
	logic [3:0] cnt_r;
	logic [2:0] sd_r;

	// quiet bus at time zero
	initial begin
		data_out = 16'h0f0f;
		ack_n_out = 1'b1;
		ready_out = 1'b1;
		cnt_r = 4'h0;
		sd_r = 3'h0;
	end

	// everything changes just after the edge, like a real slave
	always @(posedge clk_in) begin
		cnt_r <= (!cs_n_in || !prd_n_in || !pwr_n_in) ? cnt_r + 4'h1 : 4'h0;
		sd_r <= (!cas_n_in && we_n_in) ? 3'h4 : ((sd_r != 3'h0) ? sd_r - 3'h1 : 3'h0);
		ack_n_out <= !(!cs_n_in && cnt_r >= delay_in);
		ready_out <= !(!(prd_n_in && pwr_n_in) && cnt_r < delay_in);
		// a released bus drifts so a stale value never passes for read data
		if (sd_r != 3'h0 || (!cas_n_in && we_n_in))
			data_out <= SD_WORD;
		else if (!rd_n_in || !prd_n_in)
			data_out <= ~addr_in[16:1];
		else
			data_out <= ~data_out;
	end
endmodule // ebi_mem_model

//--- ebi_pkg.sv
// shared constants, types and timing for the external bus interface
package ebi_pkg;
	// address and data widths
	localparam int ADDR_W      = 25;
	localparam int DATA_W      = 16;
	localparam int ROW_W       = 13;
	localparam int COL_W       = 9;
	// region decode on byte address bits 24:21 (2 MB windows)
	localparam int RGN_LSB     = 21;
	localparam logic [3:0] RGN_BOOT  = 4'h0;
	localparam logic [3:0] RGN_CS1   = 4'h1;
	localparam logic [3:0] RGN_CS2   = 4'h2;
	localparam logic [3:0] RGN_CS4   = 4'h3;
	localparam logic [3:0] RGN_SDRAM = 4'h8;   // 8..f: 16 MB... decoded by top bit
	localparam int SDRAM_BIT   = 24;           // one bit selects the 16 MB... sdram half
	// default cycle length in clocks when no slave acknowledges
	localparam int DEF_WAIT_NS = 200;
	localparam int CLK_NS      = 20;
	localparam int DEF_WAIT_CYC = (DEF_WAIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SD_CAS_LAT  = 2;
	localparam logic [1:0] CS_NONE = 2'h0;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [1:0]        size;      // 0 byte, 1 word, 2 longword
		logic [DATA_W-1:0] wdata;
	} bus_req_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ASYNC = 3'b001,
		ST_ACT   = 3'b010,
		ST_CMD   = 3'b011,
		ST_LAT   = 3'b100,
		ST_DONE  = 3'b101
	} bus_state_e;

	typedef enum logic [2:0] {
		TGT_DEFAULT = 3'h0,
		TGT_BOOT    = 3'h1,
		TGT_CS1     = 3'h2,
		TGT_CS2     = 3'h3,
		TGT_CS4     = 3'h4,
		TGT_SDRAM   = 3'h5,
		TGT_IROM    = 3'h6
	} target_e;
endpackage

//--- ebi_sync.sv
// two-stage synchroniser for inputs arriving from pins
module ebi_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	input  wire logic [W-1:0] reset_val_in,
	// asynchronous level and its synchronised copy
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// first stage feeds only the second
	always_comb begin
		meta_nxt = srst_in ? reset_val_in : d_in;
		q_nxt    = srst_in ? reset_val_in : meta_r;
	end

	always_ff @(posedge clk_in) begin
		meta_r <= meta_nxt;
		q_out  <= q_nxt;
	end
endmodule // ebi_sync

//--- external_bus_interface.sv
// external bus master: async chip selects, peripheral strobes and 16-bit sdram
// How it works
// - address carries msb byte; sdram muxes row/column
// - address bits 24..1 plus top bit shared
// - read/write high for read, low write
// - read strobe low during async read cycles, not sdram reads
// - 16-bit data bus captured on rising edge
// - writes drive all sixteen data lines
// - unmatched address runs default cycle
// - sdram is 16 bits, 16 MB only
// - row and column strobes active low
// - sdram write strobe low writing, high reads
// - sdram chip enable active low
// - upper and lower byte masks for sdram
// - bus clock to sdram, clock enable high once the strap is taken after reset
// - three chip selects, one pin shared
// - internal boot: internal rom, pin carries alternate
// - external boot: pin carries boot select
// - chip selects active low, glueless
// - peripheral strobes tied to peripheral select
// - peripheral ready stretches with wait states
// - tristate input floats every output pin
// - pins come up in primary function
module external_bus_interface
	import ebi_pkg::*;
#(
	parameter int DEF_WAIT = DEF_WAIT_CYC
) (
	// clock and reset
	input  wire logic              CLK_IN,
	input  wire logic              SRST_IN,
	// strap sampled after reset
	input  wire logic              BOOT_INTERNAL_IN,
	// internal request side
	input  wire logic              REQ_VALID_IN,
	input  bus_req_s               REQ_IN,
	output logic                   REQ_READY_OUT,
	output logic                   RSP_VALID_OUT,
	output logic      [DATA_W-1:0] RSP_DATA_OUT,
	output logic                   IROM_SEL_OUT,
	// bus pins
	output logic      [ADDR_W-1:1] ADDR_OUT,
	output logic                   TOP_ADDRESS_BIT_OUT,
	output logic                   RW_OUT,
	output logic                   READ_STROBE_N_OUT,
	input  wire logic [DATA_W-1:0] DATA_IN,
	output logic      [DATA_W-1:0] DATA_OUT,
	output logic                   DATA_OE_OUT,
	input  wire logic              TRANSFER_ACK_N_IN,
	// sdram pins
	output logic                   SDRAM_ROW_STROBE_N_OUT,
	output logic                   SDRAM_COLUMN_STROBE_N_OUT,
	output logic                   SDRAM_WRITE_STROBE_N_OUT,
	output logic                   SDRAM_CHIP_ENABLE_N_OUT,
	output logic                   SDRAM_UPPER_BYTE_MASK_OUT,
	output logic                   SDRAM_LOWER_BYTE_MASK_OUT,
	output logic                   SDRAM_CLOCK_OUT,
	output logic                   SDRAM_CLOCK_ENABLE_OUT,
	// chip selects and peripheral strobes
	output logic                   BOOT_CHIP_SELECT_N_OUT,
	output logic                   SECOND_CHIP_SELECT_N_OUT,
	output logic                   PERIPHERAL_CHIP_SELECT_N_OUT,
	output logic                   PERIPHERAL_READ_STROBE_N_OUT,
	output logic                   PERIPHERAL_WRITE_STROBE_N_OUT,
	input  wire logic              PERIPHERAL_READY_IN,
	// global float control and pin output enable
	input  wire logic              TRISTATE_ALL_IN,
	output logic                   PINS_OE_OUT
);
	localparam int WCNT_W = 8;
	localparam logic [WCNT_W-1:0] WAIT_LIM = WCNT_W'(DEF_WAIT);
	localparam logic [WCNT_W-1:0] CAS_LAT  = WCNT_W'(SD_CAS_LAT);
	// ready passes two flops, so its first answer is only seen on the third cycle
	localparam logic [WCNT_W-1:0] PER_MIN  = WCNT_W'(3);

	// synchronised pin inputs
	logic              ack_n_s;
	logic              ready_s;
	logic              hiz_s;
	logic [DATA_W-1:0] din_s;
	target_e           tgt;

	ebi_sync #(.W(3)) u_sync_ctl (
		.clk_in       (CLK_IN),
		.srst_in      (SRST_IN),
		.reset_val_in (3'b110),
		.d_in         ({TRANSFER_ACK_N_IN, PERIPHERAL_READY_IN, TRISTATE_ALL_IN}),
		.q_out        ({ack_n_s, ready_s, hiz_s})
	);

	// data is sampled straight on the rising edge, as a synchronous bus allows
	assign din_s = DATA_IN;

	// state
	bus_state_e        st_r, st_nxt;
	bus_req_s          req_r, req_nxt;
	target_e           tgt_r, tgt_nxt;
	logic [WCNT_W-1:0] cnt_r, cnt_nxt;
	logic              boot_int_r, boot_int_nxt;
	logic              strap_done_r, strap_done_nxt;
	logic              rsp_v_r, rsp_v_nxt;
	logic [DATA_W-1:0] rsp_d_r, rsp_d_nxt;

	ebi_decode u_decode (
		.addr_in          (REQ_IN.addr),
		.boot_internal_in (boot_int_r),
		.target_out       (tgt)
	);

	// function: strobe/select active for a given target during an async cycle
	function automatic logic sel_n(input target_e t, input target_e want, input logic act);
		sel_n = !(act && t == want);
	endfunction

	// sequencing of the bus cycle; internal rom answers in one cycle
	always_comb begin
		st_nxt         = st_r;
		req_nxt        = req_r;
		tgt_nxt        = tgt_r;
		cnt_nxt        = cnt_r;
		boot_int_nxt   = boot_int_r;
		strap_done_nxt = 1'b1;
		rsp_v_nxt      = 1'b0;
		rsp_d_nxt      = rsp_d_r;
		if (!strap_done_r) begin
			boot_int_nxt = BOOT_INTERNAL_IN;                    // strap caught after release
		end
		case (st_r)
			ST_IDLE: begin
				if (REQ_VALID_IN && strap_done_r) begin
					req_nxt = REQ_IN;
					tgt_nxt = tgt;
					cnt_nxt = '0;
					st_nxt  = (tgt == TGT_SDRAM) ? ST_ACT :
					          (tgt == TGT_IROM)  ? ST_DONE : ST_ASYNC;
				end
			end
			ST_ASYNC: begin
				cnt_nxt = cnt_r + 1'b1;
				// peripheral holds off until ready; others end on ack or default count
				if (tgt_r == TGT_CS2 && cnt_r < PER_MIN) begin
					cnt_nxt = cnt_r + 1'b1;
				end else if (tgt_r == TGT_CS2 && !ready_s) begin
					cnt_nxt = cnt_r;
				end else if (!ack_n_s || cnt_r == WAIT_LIM || tgt_r == TGT_CS2) begin
					rsp_v_nxt = 1'b1;
					rsp_d_nxt = din_s;
					st_nxt    = ST_IDLE;
				end
			end
			ST_ACT: begin
				st_nxt = ST_CMD;
			end
			ST_CMD: begin
				cnt_nxt = '0;
				if (req_r.write) begin
					rsp_v_nxt = 1'b1;
					st_nxt    = ST_IDLE;
				end else begin
					st_nxt = ST_LAT;
				end
			end
			ST_LAT: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == CAS_LAT - 1'b1) begin
					rsp_v_nxt = 1'b1;
					rsp_d_nxt = din_s;
					st_nxt    = ST_IDLE;
				end
			end
			ST_DONE: begin
				rsp_v_nxt = 1'b1;
				rsp_d_nxt = '0;
				st_nxt    = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
		if (SRST_IN) begin
			st_nxt         = ST_IDLE;
			req_nxt        = '0;
			tgt_nxt        = TGT_DEFAULT;
			cnt_nxt        = '0;
			boot_int_nxt   = 1'b0;
			strap_done_nxt = 1'b0;
			rsp_v_nxt      = 1'b0;
			rsp_d_nxt      = '0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		st_r         <= st_nxt;
		req_r        <= req_nxt;
		tgt_r        <= tgt_nxt;
		cnt_r        <= cnt_nxt;
		boot_int_r   <= boot_int_nxt;
		strap_done_r <= strap_done_nxt;
		rsp_v_r      <= rsp_v_nxt;
		rsp_d_r      <= rsp_d_nxt;
	end

	logic in_async;
	logic in_sd;
	logic sd_row_addr;
	logic pin_alt;
	assign in_async    = (st_r == ST_ASYNC);
	assign in_sd       = (st_r == ST_ACT) || (st_r == ST_CMD) || (st_r == ST_LAT);
	assign sd_row_addr = (st_r == ST_ACT);
	assign pin_alt     = in_async && (tgt_r == TGT_CS4);

	// request side
	assign REQ_READY_OUT = (st_r == ST_IDLE) && strap_done_r;
	assign RSP_VALID_OUT = rsp_v_r;
	assign RSP_DATA_OUT  = rsp_d_r;
	assign IROM_SEL_OUT  = (st_r == ST_DONE);

	// address: byte address, row then column for sdram
	always_comb begin
		ADDR_OUT = req_r.addr[ADDR_W-1:1];
		if (in_sd) begin
			ADDR_OUT = '0;
			ADDR_OUT[ROW_W:1] = sd_row_addr ? req_r.addr[ROW_W+COL_W:COL_W+1]
			                                : {4'h0, req_r.addr[COL_W:1]};
		end
	end
	// top bit shares the bit-20 pin: it carries bit 24 only for sdram row
	assign TOP_ADDRESS_BIT_OUT = (in_sd && sd_row_addr) ? req_r.addr[24] : req_r.addr[20];

	// read/write held for the whole cycle; output enable only in async and sdram command states
	assign RW_OUT            = (st_r == ST_IDLE) ? 1'b1 : !req_r.write;
	assign READ_STROBE_N_OUT = !(in_async && !req_r.write);
	assign DATA_OUT          = req_r.wdata;
	assign DATA_OE_OUT       = (in_async || st_r == ST_CMD) && req_r.write && !hiz_s;

	// sdram command pins: activate, then read or write command
	assign SDRAM_CHIP_ENABLE_N_OUT   = !((st_r == ST_ACT) || (st_r == ST_CMD));
	assign SDRAM_ROW_STROBE_N_OUT    = !(st_r == ST_ACT);
	assign SDRAM_COLUMN_STROBE_N_OUT = !(st_r == ST_CMD);
	assign SDRAM_WRITE_STROBE_N_OUT  = !(st_r == ST_CMD && req_r.write);
	// byte masks: a byte access to an odd address keeps only the low lane
	assign SDRAM_UPPER_BYTE_MASK_OUT = in_sd && req_r.size == 2'h0 && req_r.addr[0];
	assign SDRAM_LOWER_BYTE_MASK_OUT = in_sd && req_r.size == 2'h0 && !req_r.addr[0];
	assign SDRAM_CLOCK_OUT           = CLK_IN;
	assign SDRAM_CLOCK_ENABLE_OUT    = strap_done_r;

	// chip selects, shared pin follows boot mode
	assign BOOT_CHIP_SELECT_N_OUT = pin_alt ? 1'b0 :
	                                sel_n(tgt_r, TGT_BOOT, in_async);
	assign SECOND_CHIP_SELECT_N_OUT     = sel_n(tgt_r, TGT_CS1, in_async);
	assign PERIPHERAL_CHIP_SELECT_N_OUT = sel_n(tgt_r, TGT_CS2, in_async);
	assign PERIPHERAL_READ_STROBE_N_OUT  = !(in_async && tgt_r == TGT_CS2 && !req_r.write);
	assign PERIPHERAL_WRITE_STROBE_N_OUT = !(in_async && tgt_r == TGT_CS2 && req_r.write);

	// all pins float while the float control is high; primary function from reset on
	assign PINS_OE_OUT = !hiz_s;

	// checks
	a_rw_level: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		in_async |-> RW_OUT == !req_r.write) else $error("rw level wrong");
	a_oe_read: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		(in_async && !req_r.write) |-> !READ_STROBE_N_OUT) else $error("read strobe missing");
	a_we_read: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		(in_sd && !req_r.write) |-> SDRAM_WRITE_STROBE_N_OUT) else $error("sdram we in read");
	a_ras_cas: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		!SDRAM_ROW_STROBE_N_OUT |=> !SDRAM_COLUMN_STROBE_N_OUT) else $error("cas not after ras");
	a_default_end: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		(in_async && tgt_r != TGT_CS2 && cnt_r == WAIT_LIM) |=> rsp_v_r) else $error("default cycle hung");
	a_ack_end: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		(in_async && tgt_r != TGT_CS2 && !ack_n_s) |=> (st_r == ST_IDLE && rsp_v_r)) else $error("ack ignored");
	a_wait_ready: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		(in_async && tgt_r == TGT_CS2 && !ready_s) |=> in_async) else $error("wait not held");
	a_float_all: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		hiz_s |-> (!PINS_OE_OUT && !DATA_OE_OUT)) else $error("pins not floated");
	a_one_sel: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
		!PERIPHERAL_READ_STROBE_N_OUT |-> (!PERIPHERAL_CHIP_SELECT_N_OUT && BOOT_CHIP_SELECT_N_OUT)) else $error("strobe without select");
	c_sd_read:  cover property (@(posedge CLK_IN) st_r == ST_LAT ##1 rsp_v_r);
	c_periph:   cover property (@(posedge CLK_IN) in_async && tgt_r == TGT_CS2 && !ready_s);
	c_alt_cs:   cover property (@(posedge CLK_IN) pin_alt);
endmodule // external_bus_interface

//--- testbench.sv
// self-checking bench for the external bus interface and its far-side model
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ebi_pkg::*;
	localparam logic [15:0] SD_WORD = 16'hc3a5;

	// design pins
	logic CLK_IN, SRST_IN, BOOT_INTERNAL_IN, REQ_VALID_IN, REQ_READY_OUT, RSP_VALID_OUT;
	logic IROM_SEL_OUT, TOP_ADDRESS_BIT_OUT, RW_OUT, READ_STROBE_N_OUT, DATA_OE_OUT;
	logic TRANSFER_ACK_N_IN, SDRAM_ROW_STROBE_N_OUT, SDRAM_COLUMN_STROBE_N_OUT;
	logic SDRAM_WRITE_STROBE_N_OUT, SDRAM_CHIP_ENABLE_N_OUT, SDRAM_UPPER_BYTE_MASK_OUT;
	logic SDRAM_LOWER_BYTE_MASK_OUT, SDRAM_CLOCK_OUT, SDRAM_CLOCK_ENABLE_OUT;
	logic BOOT_CHIP_SELECT_N_OUT, SECOND_CHIP_SELECT_N_OUT, PERIPHERAL_CHIP_SELECT_N_OUT;
	logic PERIPHERAL_READ_STROBE_N_OUT, PERIPHERAL_WRITE_STROBE_N_OUT, PERIPHERAL_READY_IN;
	logic TRISTATE_ALL_IN, PINS_OE_OUT;
	bus_req_s          REQ_IN;
	logic [DATA_W-1:0] RSP_DATA_OUT, DATA_IN, DATA_OUT;
	logic [ADDR_W-1:1] ADDR_OUT;
	// bench state
	logic [3:0]        dly;
	logic [10:0]       pins;
	logic [16:0]       note;
	logic [16:0]       exp_q[$];
	logic [31:0]       r;
	logic [ADDR_W-1:0] a;
	int                seed = 32'h809f;
	int                errors, tests_run, lat, cyc;

	external_bus_interface #(.DEF_WAIT(3)) dut (.*);

	ebi_mem_model #(.SD_WORD(SD_WORD)) far (.clk_in(CLK_IN), .delay_in(dly),
		.addr_in(ADDR_OUT), .rd_n_in(READ_STROBE_N_OUT),
		.cs_n_in(BOOT_CHIP_SELECT_N_OUT & SECOND_CHIP_SELECT_N_OUT),
		.prd_n_in(PERIPHERAL_READ_STROBE_N_OUT), .pwr_n_in(PERIPHERAL_WRITE_STROBE_N_OUT),
		.cas_n_in(SDRAM_COLUMN_STROBE_N_OUT), .we_n_in(SDRAM_WRITE_STROBE_N_OUT),
		.data_out(DATA_IN), .ack_n_out(TRANSFER_ACK_N_IN), .ready_out(PERIPHERAL_READY_IN));

	// strobes folded into one vector: selects, strobes, rw, then sdram controls
	assign pins = {BOOT_CHIP_SELECT_N_OUT, SECOND_CHIP_SELECT_N_OUT,
		PERIPHERAL_CHIP_SELECT_N_OUT, PERIPHERAL_READ_STROBE_N_OUT,
		PERIPHERAL_WRITE_STROBE_N_OUT, READ_STROBE_N_OUT, RW_OUT, SDRAM_ROW_STROBE_N_OUT,
		SDRAM_COLUMN_STROBE_N_OUT, SDRAM_WRITE_STROBE_N_OUT, SDRAM_CHIP_ENABLE_N_OUT};

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one transfer; pins are and-ed over the cycle so any low strobe is caught
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] ad, input logic [10:0] exp,
			input logic [10:0] msk, input logic chk, input logic [15:0] ed, input logic ir);
		logic [10:0]       seen;
		logic [DATA_W-1:0] wd, wcap;
		logic [ADDR_W-1:1] acap;
		logic              rdy, got, irs, topc;
		int                n;
		wd = 16'($random(seed));
		seen = '1;
		got = 1'b0;
		irs = 1'b0;
		n = 0;
		lat = 0;
		exp_q.push_back({chk, ed});
		REQ_VALID_IN <= 1'b1;
		REQ_IN <= '{write: wr, addr: ad, size: 2'h1, wdata: wd};
		do begin
			@(negedge CLK_IN);
			rdy = REQ_READY_OUT;
			irs |= IROM_SEL_OUT;
			@(posedge CLK_IN);
		end while (rdy !== 1'b1 && ++n < 50);
		REQ_VALID_IN <= 1'b0;
		while (got !== 1'b1 && lat < 50) begin
			@(negedge CLK_IN);
			lat++;
			seen &= pins;
			irs |= IROM_SEL_OUT;
			got = RSP_VALID_OUT;
			if (pins[10:8] != 3'h7) begin
				acap = ADDR_OUT;
				topc = TOP_ADDRESS_BIT_OUT;
			end
			if (DATA_OE_OUT === 1'b1)
				wcap = DATA_OUT;
			@(posedge CLK_IN);
		end
		check("response", got, 1'b1);
		check("pins", seen | msk, exp | msk);
		check("rom select", irs, ir);
		if (exp[10:8] != 3'h7) begin
			check("address", acap, ad[ADDR_W-1:1]);
			check("top bit", topc, ad[20]);
		end
		if (wr)
			check("write data", wcap, wd);
		// gap lets the synchronised answer of the slave die away
		repeat (4) @(posedge CLK_IN);
	endtask

	// response watcher takes the oldest note on every answer
	always @(negedge CLK_IN) begin
		if (RSP_VALID_OUT === 1'b1) begin
			note = exp_q.pop_front();
			if (note[16])
				check("read data", RSP_DATA_OUT, note[15:0]);
		end
	end

	// hang guard well beyond the few hundred cycles the run needs
	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		CLK_IN = 1'b0;
		forever #10 CLK_IN = ~CLK_IN;
	end

	initial begin
		SRST_IN = 1'b1;
		BOOT_INTERNAL_IN = 1'b0;
		REQ_VALID_IN = 1'b0;
		REQ_IN = '0;
		TRISTATE_ALL_IN = 1'b0;
		dly = 4'h0;
		repeat (20) @(posedge CLK_IN);
		SRST_IN <= 1'b0;
		repeat (3) @(negedge CLK_IN);
		check("idle pins", pins, 11'h7ff);
		check("clock enable", SDRAM_CLOCK_ENABLE_OUT, 1'b1);
		@(posedge CLK_IN);
		// prompt then slow slaves
		for (int d = 0; d < 7; d += 6) begin
			dly <= 4'(d);
			r = $random(seed);
			xfer(1'b1, {RGN_CS1, r[20:1], 1'b0}, 11'h5ef, 11'h0, 1'b0, 16'h0, 1'b0);
			a = {RGN_BOOT, r[20:1], 1'b0};
			xfer(1'b0, a, 11'h3df, 11'h0, 1'b1, ~a[16:1], 1'b0);
			a = {RGN_CS2, r[19:0], 1'b0};
			xfer(1'b0, a, 11'h67f, 11'h020, 1'b1, ~a[16:1], 1'b0);
			if (d == 6)
				check("wait states", lat > 7, 1'b1);
			xfer(1'b1, {RGN_CS2, r[20:1], 1'b0}, 11'h6af, 11'h0, 1'b0, 16'h0, 1'b0);
		end
		xfer(1'b0, {4'h4, r[20:1], 1'b0}, 11'h7ff, 11'h020, 1'b0, 16'h0, 1'b0);
		a = {1'b1, r[23:1], 1'b0};
		xfer(1'b1, a, 11'h7e0, 11'h0, 1'b0, 16'h0, 1'b0);
		xfer(1'b0, a, 11'h7f2, 11'h020, 1'b1, SD_WORD, 1'b0);
		TRISTATE_ALL_IN <= 1'b1;
		repeat (5) @(posedge CLK_IN);
		check("pins float", PINS_OE_OUT, 1'b0);
		TRISTATE_ALL_IN <= 1'b0;
		repeat (5) @(posedge CLK_IN);
		check("pins driven", PINS_OE_OUT, 1'b1);
		// second reset with the internal rom strap
		BOOT_INTERNAL_IN <= 1'b1;
		SRST_IN <= 1'b1;
		repeat (20) @(posedge CLK_IN);
		SRST_IN <= 1'b0;
		repeat (3) @(posedge CLK_IN);
		xfer(1'b0, {RGN_BOOT, r[20:1], 1'b0}, 11'h7ff, 11'h020, 1'b1, 16'h0, 1'b1);
		a = {RGN_CS4, r[20:1], 1'b0};
		xfer(1'b0, a, 11'h3df, 11'h0, 1'b1, ~a[16:1], 1'b0);
		conclude();
	end
endmodule // testbench
